// file: rtl/tone_port_cfg.svh
`ifndef TONE_PORT_CFG_SVH
`define TONE_PORT_CFG_SVH
// control register A fields
`define CTLA_TONE_EN 0
`define CTLA_CP_SEL 1
`define CTLA_IRQ_EN 2
`define CTLA_SEL_B 3
// control register B fields
`define CTLB_BURST_OFF 0
`define CTLB_TEST 1
`define CTLB_SINGLE 2
`define CTLB_COLUMN 3
// status fields
`define ST_IRQ 0
`define ST_TX_EMPTY 1
`define ST_RX_FULL 2
`define ST_DSTEER 3
// register select values
`define SEL_DATA 1'b0
`define SEL_CTRL 1'b1
// burst timing and control reset value
`define BURST_MS 51
`define BURST_CP_MS 102
`define CLK_KHZ 40000
`define CTRL_RESET 4'h0
`endif

// file: rtl/tone_port_pkg.sv
package tone_port_pkg;
  typedef enum logic [1:0] {BURST_IDLE, BURST_TONE, BURST_PAUSE} burst_e;
  typedef logic [3:0] nib_t;
endpackage : tone_port_pkg

// file: rtl/tone_port_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tone_port_if;
  logic csN;
  logic registerSelectLine;
  logic wrN;
  logic rdN;
  logic [3:0] dataFromHost;
  logic [3:0] dataFromDev;
  logic dataDevOe;
  logic irqOut;
  logic irqOe;
  // open-drain level seen on the wire with external pull-up
  logic interruptOrToneOutput;
  assign interruptOrToneOutput = irqOe ? irqOut : 1'b1;
  modport dev (input csN, input registerSelectLine, input wrN, input rdN, input dataFromHost,
    output dataFromDev, output dataDevOe, output irqOut, output irqOe);
  modport host (output csN, output registerSelectLine, output wrN, output rdN, output dataFromHost,
    input dataFromDev, input dataDevOe, input interruptOrToneOutput);
endinterface : tone_port_if
`default_nettype wire

// file: rtl/tone_transceiver_port.sv
// Behaviour
// RULE1: data select write loads transmit data
// RULE2: data select read returns receive data
// RULE3: control select write goes to target register
// RULE4: control select read returns status
// RULE5: exactly five registers exposed
// RULE6: both control registers share one address
// RULE7: A bit3 steers only next write to B
// RULE8: host issues software reset at start
// RULE9: host forms chip select from decode
// RULE10: accesses finish without wait states
// RULE11: shared output is open drain
// RULE12: A bit0 gates all transmit tones
// RULE13: A bit1 selects call progress mode
// RULE14: no digit detection in call progress
// RULE15: irq low on digit or tx ready
// RULE16: burst write gives 51ms tone, pause
// RULE17: call progress burst doubles to 102ms
// RULE18: no burst: tone follows enable bit
// RULE19: test bit mirrors delayed steering output
// RULE20: B bit2 selects single tone
// RULE21: B bit3 picks column or row
// RULE22: status irq bit from b1 or b2
// RULE23: tx empty set after pause end
// RULE24: pointer targets A after reset
`timescale 1ns/1ps
`default_nettype none
`include "tone_port_cfg.svh"
module tone_transceiver_port #(
  parameter int BURST_CYC = (`BURST_MS * `CLK_KHZ),
  parameter int BURST_CP_CYC = (`BURST_CP_MS * `CLK_KHZ)
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // host bus
  tone_port_if.dev bus,
  // receiver side
  input wire logic digitValid,
  input wire logic [3:0] digitCode,
  input wire logic delayedSteering,
  input wire logic cpSquare,
  // transmitter side
  output logic toneOn,
  output logic singleTone,
  output logic columnTone,
  output logic [3:0] toneCode,
  output logic cpMode,
  output logic rxEnable
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    tone_port_pkg::nib_t txData;
    tone_port_pkg::nib_t rxData;
    tone_port_pkg::nib_t control_reg_a;
    tone_port_pkg::nib_t control_reg_b;
    logic ptrB;
    logic txEmpty;
    logic rxFull;
    logic rdPrev;
    logic wrPrev;
    tone_port_pkg::nib_t rdData;
    tone_port_pkg::burst_e burst;
    logic [31:0] cnt;
  } state_s;
  state_s s_r;
  state_s s_nxt;
  logic rdStrobe;
  logic wrStrobe;
  logic [3:0] status;
  logic [31:0] period;
  logic burstOn;
  logic irqLevel;
  logic lineLow;
  assign rdStrobe = !bus.csN && !bus.rdN && bus.wrN;
  assign wrStrobe = !bus.csN && !bus.wrN && bus.rdN;
  assign burstOn = !s_r.control_reg_b[`CTLB_BURST_OFF];
  assign period = s_r.control_reg_a[`CTLA_CP_SEL] ? 32'(BURST_CP_CYC) : 32'(BURST_CYC); // [RULE16] [RULE17]
  assign status = {delayedSteering, s_r.rxFull, s_r.txEmpty, s_r.rxFull | s_r.txEmpty}; // [RULE22]
  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rdPrev = rdStrobe;
    s_nxt.wrPrev = wrStrobe;
    // receive capture, blocked in call progress mode
    if (digitValid && !s_r.control_reg_a[`CTLA_CP_SEL]) // [RULE14]
    begin
      s_nxt.rxData = digitCode;
      s_nxt.rxFull = 1'b1;
    end
    // burst sequencer
    unique case (s_r.burst)
      tone_port_pkg::BURST_IDLE:
      begin
        s_nxt.cnt = '0;
      end
      tone_port_pkg::BURST_TONE:
      begin
        s_nxt.cnt = s_r.cnt + 32'h1;
        if (s_r.cnt >= period - 32'h1)
        begin
          s_nxt.cnt = '0;
          s_nxt.burst = tone_port_pkg::BURST_PAUSE;
        end
      end
      tone_port_pkg::BURST_PAUSE:
      begin
        s_nxt.cnt = s_r.cnt + 32'h1;
        if (s_r.cnt >= period - 32'h1)
        begin
          s_nxt.burst = tone_port_pkg::BURST_IDLE;
          s_nxt.txEmpty = 1'b1; // [RULE23]
        end
      end
    endcase
    // status read clears flags on the strobe's leading edge; a set in the same cycle wins
    if (rdStrobe && !s_r.rdPrev)
    begin
      s_nxt.rdData = (bus.registerSelectLine == `SEL_CTRL) ? status : s_r.rxData; // [RULE2] [RULE4]
      if (bus.registerSelectLine == `SEL_CTRL)
      begin
        s_nxt.rxFull = digitValid && !s_r.control_reg_a[`CTLA_CP_SEL]; // [RULE22]
        // only the flag seen by this read is cleared, a pause end landing now survives
        s_nxt.txEmpty = s_nxt.txEmpty && !s_r.txEmpty; // [RULE23]
      end
    end
    if (!burstOn)
    begin
      s_nxt.txEmpty = 1'b0; // [RULE23]
      s_nxt.burst = tone_port_pkg::BURST_IDLE;
    end
    // writes are taken on the strobe's leading edge
    if (wrStrobe && !s_r.wrPrev) // [RULE10]
    begin
      if (bus.registerSelectLine == `SEL_DATA)
      begin
        s_nxt.txData = bus.dataFromHost; // [RULE1]
        if (burstOn)
        begin
          s_nxt.burst = tone_port_pkg::BURST_TONE; // [RULE16]
          s_nxt.cnt = '0;
          s_nxt.txEmpty = 1'b0;
        end
      end
      else if (s_r.ptrB) // [RULE6] [RULE3]
      begin
        s_nxt.control_reg_b = bus.dataFromHost;
        s_nxt.ptrB = 1'b0; // [RULE7]
      end
      else
      begin
        s_nxt.control_reg_a = bus.dataFromHost;
        s_nxt.ptrB = bus.dataFromHost[`CTLA_SEL_B]; // [RULE7]
      end
    end
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_r <= '0; // [RULE24]
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  // read data is held in a flop so the host can take it after the strobe
  assign bus.dataFromDev = s_r.rdData;
  assign bus.dataDevOe = rdStrobe; // [RULE5]
  always_comb
  begin
    irqLevel = 1'b0;
    if (s_r.control_reg_a[`CTLA_CP_SEL])
    begin
      irqLevel = s_r.control_reg_a[`CTLA_IRQ_EN] && cpSquare; // [RULE13]
    end
    else if (s_r.control_reg_b[`CTLB_TEST])
    begin
      irqLevel = delayedSteering; // [RULE19]
    end
    else
    begin
      irqLevel = s_r.control_reg_a[`CTLA_IRQ_EN] && status[`ST_IRQ]; // [RULE15]
    end
  end
  // test mode mirrors pin high/low directly; interrupt pulls low
  assign lineLow = (s_r.control_reg_b[`CTLB_TEST] && !s_r.control_reg_a[`CTLA_CP_SEL]) ? !irqLevel :
    (s_r.control_reg_a[`CTLA_CP_SEL] ? (s_r.control_reg_a[`CTLA_IRQ_EN] && !cpSquare) : irqLevel);
  assign bus.irqOut = 1'b0; // [RULE11]
  assign bus.irqOe = lineLow; // [RULE11]
  assign toneOn = s_r.control_reg_a[`CTLA_TONE_EN] && (!burstOn || s_r.burst == tone_port_pkg::BURST_TONE); // [RULE12] [RULE18]
  assign singleTone = s_r.control_reg_b[`CTLB_SINGLE]; // [RULE20]
  assign columnTone = s_r.control_reg_b[`CTLB_COLUMN]; // [RULE21]
  assign toneCode = s_r.txData;
  assign cpMode = s_r.control_reg_a[`CTLA_CP_SEL]; // [RULE13]
  assign rxEnable = !s_r.control_reg_a[`CTLA_CP_SEL]; // [RULE14]
endmodule : tone_transceiver_port
`default_nettype wire

// file: rtl/tone_port_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "tone_port_cfg.svh"
module tone_port_host (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // device link
  tone_port_if.host bus
);
  // ****************************************
  // state
  // ****************************************
  // address 0 data register, 1 control/status register, 2 line level
  typedef enum logic [2:0] {IDLE, SETUP, STROBE, CAPTURE, DONE} phase_e;
  typedef struct packed {
    phase_e phase;
    logic [3:0] rdata;
  } state_s;
  state_s s_r;
  state_s s_nxt;
  logic isLine;
  assign isLine = (address[1] == 1'b1);
  always_comb
  begin
    s_nxt = s_r;
    unique case (s_r.phase)
      IDLE:
      begin
        if ((read || write) && !isLine)
        begin
          s_nxt.phase = SETUP;
        end
      end
      SETUP:
      begin
        s_nxt.phase = STROBE;
      end
      STROBE:
      begin
        s_nxt.phase = CAPTURE;
      end
      // device read data is registered on the strobe, so it is taken one cycle later
      CAPTURE:
      begin
        s_nxt.rdata = bus.dataFromDev; // [RULE2] [RULE4]
        s_nxt.phase = DONE;
      end
      DONE:
      begin
        s_nxt.phase = IDLE;
      end
      default:
      begin
        s_nxt.phase = IDLE;
      end
    endcase
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  assign waitrequest = (read || write) && !isLine && (s_r.phase != DONE);
  assign readdata = isLine ? {31'h0, bus.interruptOrToneOutput} : {28'h0, s_r.rdata};
  assign bus.csN = !(s_r.phase == SETUP || s_r.phase == STROBE); // [RULE9]
  assign bus.registerSelectLine = address[0]; // [RULE1] [RULE2] [RULE3] [RULE4]
  assign bus.wrN = !(write && s_r.phase == STROBE);
  assign bus.rdN = !(read && s_r.phase == STROBE);
  assign bus.dataFromHost = writedata[3:0];
endmodule : tone_port_host
`default_nettype wire

// file: dv/tone_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tone_port_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link
  input wire logic csN,
  input wire logic registerSelectLine,
  input wire logic wrN,
  input wire logic rdN,
  input wire logic [3:0] dataFromHost,
  input wire logic [3:0] dataFromDev,
  input wire logic dataDevOe,
  input wire logic irqOut,
  input wire logic irqOe
);
  // ****
  // link checks
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_open;
    $fell(csN) ##1 (!wrN || !rdN);
  endsequence
  property p_access;
    s_open |=> csN;
  endproperty
  a_access: assert property (p_access) else $error("select held past strobe");
  property p_cs;
    $fell(csN) |=> !csN;
  endproperty
  a_cs: assert property (p_cs) else $error("select too short");
  property p_wrPulse;
    $fell(wrN) |=> wrN;
  endproperty
  a_wrPulse: assert property (p_wrPulse) else $error("write strobe not one cycle");
  property p_rdPulse;
    $fell(rdN) |=> rdN;
  endproperty
  a_rdPulse: assert property (p_rdPulse) else $error("read strobe not one cycle");
  property p_wrCs;
    !wrN |-> !csN && rdN;
  endproperty
  a_wrCs: assert property (p_wrCs) else $error("bad write strobe");
  property p_rdCs;
    !rdN |-> !csN && wrN;
  endproperty
  a_rdCs: assert property (p_rdCs) else $error("bad read strobe");
  property p_oe;
    dataDevOe |-> !csN;
  endproperty
  a_oe: assert property (p_oe) else $error("device drives while unselected");
  property p_drain;
    irqOe |-> irqOut == 1'b0;
  endproperty
  a_drain: assert property (p_drain) else $error("shared line driven high");
  property p_sel;
    !csN && $past(!csN) |-> $stable(registerSelectLine);
  endproperty
  a_sel: assert property (p_sel) else $error("select line moved in cycle");
endmodule : tone_port_sva
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 0, rst = 1, read = 0, write = 0, waitrequest;
  logic digitValid = 0, delayedSteering = 1, cpSquare = 0;
  logic [1:0] address = 2'h0;
  logic [3:0] digitCode = 4'h0, toneCode;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic toneOn, singleTone, columnTone, cpMode, rxEnable;
  int fail_count = 0, check_count = 0, cyc = 0, n;
  tone_port_if bus();
  tone_transceiver_port #(.BURST_CYC(20), .BURST_CP_CYC(40)) u_tone_transceiver_port (.mclk(mclk), .rst(rst),
    .bus(bus), .digitValid(digitValid), .digitCode(digitCode), .delayedSteering(delayedSteering),
    .cpSquare(cpSquare), .toneOn(toneOn), .singleTone(singleTone), .columnTone(columnTone),
    .toneCode(toneCode), .cpMode(cpMode), .rxEnable(rxEnable));
  tone_port_host u_tone_port_host (.mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .bus(bus));
  tone_port_sva u_tone_port_sva (.mclk(mclk), .rst(rst), .csN(bus.csN), .registerSelectLine(bus.registerSelectLine),
    .wrN(bus.wrN), .rdN(bus.rdN), .dataFromHost(bus.dataFromHost), .dataFromDev(bus.dataFromDev),
    .dataDevOe(bus.dataDevOe), .irqOut(bus.irqOut), .irqOe(bus.irqOe));
  // ****
  // helpers
  // ****
  initial forever #12.5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      fail_count++;
      conclude();
    end
  end
  task conclude();
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [3:0] e, input logic [3:0] s);
    check_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // avalon access: request held until the edge at which waitrequest is sampled low
  task av(input logic w, input logic [1:0] a, input logic [3:0] d);
    @(posedge mclk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= {28'h0, d};
    @(posedge mclk);
    while (waitrequest !== 1'b0) @(posedge mclk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : av
  // ****
  // scenarios
  // ****
  task t_ctrl();
    chk("reset", 4'h0, {toneOn, singleTone, columnTone, cpMode});
    av(0, 2'h1, 4'h0);
    av(1, 2'h1, 4'h0);
    av(1, 2'h1, 4'h0);
    av(1, 2'h1, 4'h8);
    av(1, 2'h1, 4'h0);
    av(0, 2'h1, 4'h0);
    chk("swReset", 4'h8, q[3:0]);
    av(1, 2'h1, 4'h9);
    av(1, 2'h1, 4'hD);
    chk("ctrlB", 4'hE, {toneOn, singleTone, columnTone, cpMode});
    av(1, 2'h1, 4'h2);
    chk("ctrlA", 4'h7, {toneOn, singleTone, columnTone, cpMode});
    chk("rxEn", 4'h0, {3'h0, rxEnable});
  endtask : t_ctrl
  task t_rx();
    av(1, 2'h1, 4'h4);
    @(posedge mclk);
    digitValid <= 1;
    digitCode <= 4'h5;
    @(posedge mclk);
    digitValid <= 0;
    repeat (3) @(posedge mclk);
    chk("lineRx", 4'h0, {3'h0, bus.interruptOrToneOutput});
    av(0, 2'h0, 4'h0);
    av(0, 2'h0, 4'h0);
    chk("rxData", 4'h5, q[3:0]);
    av(0, 2'h1, 4'h0);
    chk("status", 4'hD, q[3:0]);
    chk("lineFree", 4'h1, {3'h0, bus.interruptOrToneOutput});
  endtask : t_rx
  task t_burst();
    av(1, 2'h1, 4'hD);
    av(1, 2'h1, 4'h0);
    av(1, 2'h0, 4'h7);
    chk("burstOn", 4'h7, toneCode);
    chk("toneOn", 4'h1, {3'h0, toneOn});
    for (n = 0; n < 60 && bus.interruptOrToneOutput !== 1'b0; n++) @(posedge mclk);
    chk("burstLen", 4'h1, {3'h0, n inside {[30:45]}});
    chk("toneOff", 4'h0, {3'h0, toneOn});
    av(0, 2'h1, 4'h0);
    chk("txEmpty", 4'hB, q[3:0]);
  endtask : t_burst
  task t_test();
    av(1, 2'h1, 4'h8);
    av(1, 2'h1, 4'h3);
    av(1, 2'h3, 4'hF);
    chk("unmapped", 4'h0, {3'h0, cpMode});
    delayedSteering <= 0;
    repeat (3) @(posedge mclk);
    chk("mirrorLo", 4'h0, {3'h0, bus.interruptOrToneOutput});
    delayedSteering <= 1;
    repeat (3) @(posedge mclk);
    chk("mirrorHi", 4'h1, {3'h0, bus.interruptOrToneOutput});
  endtask : t_test
  initial
  begin
    repeat (4) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    t_ctrl();
    t_rx();
    t_burst();
    t_test();
    conclude();
  end
endmodule : testbench
`default_nettype wire
